// ---- verilog/twowire_pkg.sv ----
// Purpose: shared constants and types of the two-wire master transmitter
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: status codes keep their low three bits at zero
package twowire_pkg;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] DATA_OFF = 8'h08;
	localparam logic [7:0] EVT_OFF = 8'h0C;
	localparam logic [7:0] MASK_OFF = 8'h10;
	localparam int CTL_FLAG = 7;
	localparam int CTL_ACK = 6;
	localparam int CTL_STA = 5;
	localparam int CTL_STO = 4;
	localparam int CTL_WC = 3;
	localparam int CTL_EN = 2;
	localparam int CTL_IE = 0;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_SLAW_ACK = 8'h18;
	localparam logic [7:0] ST_SLAW_NACK = 8'h20;
	localparam logic [7:0] ST_DATA_ACK = 8'h28;
	localparam logic [7:0] ST_DATA_NACK = 8'h30;
	localparam logic [7:0] ST_ARB = 8'h38;
	localparam logic [7:0] ST_SLAR_ACK = 8'h40;
	localparam logic [7:0] ST_SLAR_NACK = 8'h48;
	localparam logic [7:0] ST_IDLE = 8'hF8;
	localparam logic [7:0] STATUS_MASK = 8'hF8;
	localparam int EVT_FLAG = 0;
	localparam int EVT_WC = 1;
	localparam int EVT_ARB = 2;
	localparam int EVT_W = 3;
	localparam int CLK_NS = 4;
	localparam int SCL_BIT_NS = 2500;
	localparam int QUARTER_CYC = SCL_BIT_NS / (4 * CLK_NS);
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BYTE} cmd_t;
endpackage

// ---- verilog/twowire_engine_if.sv ----
// Purpose: command path between sequencer and bit engine
// Assumes: go and done are one-cycle pulses
// Notes: none
`timescale 1ns/1ps
interface twowire_engine_if;
	import twowire_pkg::*;
	cmd_t cmd;
	logic go;
	logic [7:0] tx_byte;
	logic done;
	logic lost;
	logic ack;
	modport seq(output cmd, output go, output tx_byte, input done, input lost, input ack);
	modport eng(input cmd, input go, input tx_byte, output done, output lost, output ack);
endinterface

// ---- verilog/twowire_bit_engine.sv ----
// Purpose: START, STOP and byte-with-ack bit timing on the open-drain pair
// Assumes: an enable high on a pin pulls that line low
// Notes: waits out clock stretching and a busy bus before its own START
`timescale 1ns/1ps
module twowire_bit_engine import twowire_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	twowire_engine_if.eng eif,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe,
	output logic sda_oe,
	output logic line_low
);
	typedef enum logic [1:0] {E_IDLE = 2'b00, E_START = 2'b01, E_BYTE = 2'b11,
		E_STOP = 2'b10} estate_t;
	estate_t st;
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic scl_f;
	logic sda_f;
	logic sda_prev;
	logic busy;
	logic owned;
	logic [7:0] cnt;
	logic [1:0] step;
	logic [3:0] bitn;
	logic [7:0] shreg;
	logic tick;
	logic adv;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_i};
			sda_s <= {sda_s[1:0], sda_i};
			if (scl_s[1] == scl_s[2]) begin
				scl_f <= scl_s[2];
			end
			if (sda_s[1] == sda_s[2]) begin
				sda_f <= sda_s[2];
			end
		end
	end

	// Any master's START or STOP seen on the wires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sda_prev <= 1'b1;
			busy <= 1'b0;
		end else begin
			sda_prev <= sda_f;
			if (scl_f && sda_prev && !sda_f) begin
				busy <= 1'b1;
			end else if (scl_f && !sda_prev && sda_f) begin
				busy <= 1'b0;
			end
		end
	end

	assign tick = (cnt == QUARTER_LAST);
	// Step 2 needs the clock line really high; a foreign bus holds our START
	assign adv = tick && !(step == 2'd2 && !scl_f)
		&& !(st == E_START && step == 2'd2 && busy && !owned);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_low <= 1'b0;
		end else begin
			line_low <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= E_IDLE;
			cnt <= 8'h00;
			step <= 2'h0;
			bitn <= 4'h0;
			shreg <= 8'h00;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			owned <= 1'b0;
			eif.done <= 1'b0;
			eif.lost <= 1'b0;
			eif.ack <= 1'b0;
		end else begin
			eif.done <= 1'b0;
			if (st == E_IDLE) begin
				cnt <= 8'h00;
				step <= 2'h0;
				bitn <= 4'h0;
				if (eif.go) begin
					eif.lost <= 1'b0;
					shreg <= eif.tx_byte;
					case (eif.cmd)
						CMD_START: st <= E_START;
						CMD_STOP: st <= E_STOP;
						default: st <= E_BYTE;
					endcase
				end
			end else if (!adv) begin
				if (!tick) begin
					cnt <= cnt + 8'h01;
				end
			end else begin
				cnt <= 8'h00;
				step <= step + 2'h1;
				case (st)
					E_START: begin
						case (step)
							2'd0: sda_oe <= 1'b0;
							2'd1: scl_oe <= 1'b0;
							2'd2: sda_oe <= 1'b1;
							default: begin
								scl_oe <= 1'b1;
								owned <= 1'b1;
								st <= E_IDLE;
								eif.done <= 1'b1;
							end
						endcase
					end
					E_STOP: begin
						case (step)
							2'd0: sda_oe <= 1'b1;
							2'd1: scl_oe <= 1'b0;
							2'd2: sda_oe <= 1'b0;
							default: begin
								owned <= 1'b0;
								st <= E_IDLE;
								eif.done <= 1'b1;
							end
						endcase
					end
					default: begin
						case (step)
							2'd0: sda_oe <= (bitn < ACK_BIT) ? !shreg[7] : 1'b0;
							2'd1: scl_oe <= 1'b0;
							2'd2: begin
								// Released a one but the line reads low
								if (bitn < ACK_BIT && !sda_oe && !sda_f) begin
									scl_oe <= 1'b0;
									owned <= 1'b0;
									eif.lost <= 1'b1;
									st <= E_IDLE;
									eif.done <= 1'b1;
								end else if (bitn == ACK_BIT) begin
									eif.ack <= !sda_f;
								end
							end
							default: begin
								scl_oe <= 1'b1;
								shreg <= {shreg[6:0], 1'b0};
								bitn <= bitn + 4'h1;
								if (bitn == ACK_BIT) begin
									st <= E_IDLE;
									eif.done <= 1'b1;
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule // twowire_bit_engine

// ---- verilog/twowire_master_tx_sequencer.sv ----
// Purpose: master-transmitter sequencing of a two-wire bus behind AXI4-Lite
// Assumes: single-beat AXI4-Lite master; registers sit in byte lane 0
// Notes: master receive data phase and slave modes are not built
// Contract
// - Start request after transfer reports 0x10, flag set
// - Repeated START keeps bus; any address allowed
// - Status 0x08: load address, clear flag, send
// - In 0x10 write address sends, stays transmitting
// - In 0x10 read address sends, switches to receive
// - Address ack gives 0x18, nack 0x20, flag
// - Data ack gives 0x28, nack 0x30, flag
// - In 0x18..0x30 loaded byte is sent
// - In 0x18..0x30 start alone sends repeated START
// - Stop alone sends STOP, clears stop bit
// - Start and stop send STOP then START
// - Lost arbitration reports 0x38 and sets flag
// - In 0x38 no start releases bus, unaddressed
// - In 0x38 start waits bus free, STARTs
// - Status low three bits read as zero
// - Transfer suspended while flag set; one clears
// - Data write without flag dropped, collision set
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module twowire_master_tx_sequencer import twowire_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq
);
	typedef enum logic [2:0] {S_IDLE = 3'b000, S_START = 3'b001, S_HOLD = 3'b011,
		S_BYTE = 3'b111, S_STOP = 3'b010} state_t;

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == CTRL_OFF) || (a == STAT_OFF) || (a == DATA_OFF)
			|| (a == EVT_OFF) || (a == MASK_OFF);
	endfunction

	twowire_engine_if eif();
	logic line_low;
	state_t state;
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_lane0;
	logic wr_fire;
	logic wr_en;
	logic wr_ctl;
	logic wr_dat;
	logic rd_fire;
	logic rd_evt;
	logic [31:0] next_rdata;
	logic flag;
	logic ack_en;
	logic start_request_bit;
	logic stop_request_bit;
	logic wc;
	logic en;
	logic ie;
	logic [7:0] data_reg;
	logic [7:0] status;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] mask;
	logic [EVT_W-1:0] evt_set;
	logic master;
	logic addr_byte;
	logic rx_mode;
	logic set_flag;
	logic stop_done;
	logic arb_set;

	twowire_bit_engine u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.eif(eif.eng),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe),
		.line_low(line_low)
	);
	assign scl_o = line_low;
	assign sda_o = line_low;

	assign wr_fire = aw_held && w_held && !bvalid;
	assign wr_en = wr_fire && wr_lane0 && reg_known(wr_addr);
	assign wr_ctl = wr_en && (wr_addr == CTRL_OFF);
	assign wr_dat = wr_en && (wr_addr == DATA_OFF);
	assign rd_fire = arvalid && arready;
	assign rd_evt = rd_fire && (araddr == EVT_OFF);

	// Address and data may arrive in either order; answer once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			wr_lane0 <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				wr_addr <= awaddr;
				aw_held <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wr_data <= wdata[7:0];
				wr_lane0 <= wstrb[0];
				w_held <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (araddr)
			CTRL_OFF: next_rdata[7:0] = {flag, ack_en, start_request_bit, stop_request_bit, wc, en, 1'b0, ie};
			STAT_OFF: next_rdata[7:0] = status & STATUS_MASK;
			DATA_OFF: next_rdata[7:0] = data_reg;
			EVT_OFF: next_rdata[EVT_W-1:0] = evt;
			MASK_OFF: next_rdata[EVT_W-1:0] = mask;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			if (rd_fire) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= next_rdata;
				rresp <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	assign set_flag = (state == S_START || state == S_BYTE) && eif.done;
	assign stop_done = (state == S_STOP) && eif.done;
	assign arb_set = (state == S_BYTE) && eif.done && eif.lost;

	// Hardware setting the flag beats a software clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag <= 1'b0;
		end else if (set_flag) begin
			flag <= 1'b1;
		end else if (wr_ctl && wr_data[CTL_FLAG]) begin
			flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_en <= 1'b0;
			start_request_bit <= 1'b0;
			stop_request_bit <= 1'b0;
			en <= 1'b0;
			ie <= 1'b0;
		end else begin
			if (stop_done) begin
				stop_request_bit <= 1'b0;
			end
			if (wr_ctl) begin
				ack_en <= wr_data[CTL_ACK];
				start_request_bit <= wr_data[CTL_STA];
				stop_request_bit <= wr_data[CTL_STO];
				en <= wr_data[CTL_EN];
				ie <= wr_data[CTL_IE];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wc <= 1'b0;
			data_reg <= DATA_RESET;
		end else if (wr_dat) begin
			wc <= !flag;
			if (flag) begin
				data_reg <= wr_data;
			end
		end
	end

	// Idle after a STOP with the start bit still set gives STOP-then-START
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			status <= ST_IDLE;
			master <= 1'b0;
			addr_byte <= 1'b0;
			rx_mode <= 1'b0;
			eif.go <= 1'b0;
			eif.cmd <= CMD_START;
			eif.tx_byte <= 8'h00;
		end else begin
			eif.go <= 1'b0;
			case (state)
				S_IDLE: begin
					if (en && start_request_bit && !flag) begin
						eif.cmd <= CMD_START;
						eif.go <= 1'b1;
						state <= S_START;
					end
				end
				S_START: begin
					if (eif.done) begin
						status <= master ? ST_RSTART : ST_START;
						master <= 1'b1;
						state <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (!flag) begin
						eif.tx_byte <= data_reg;
						addr_byte <= 1'b0;
						if (status == ST_ARB) begin
							status <= ST_IDLE;
							state <= S_IDLE;
						end else if (status == ST_START || status == ST_RSTART) begin
							addr_byte <= 1'b1;
							rx_mode <= data_reg[0];
							eif.cmd <= CMD_BYTE;
							eif.go <= 1'b1;
							state <= S_BYTE;
						end else if (stop_request_bit) begin
							eif.cmd <= CMD_STOP;
							eif.go <= 1'b1;
							state <= S_STOP;
						end else if (start_request_bit) begin
							eif.cmd <= CMD_START;
							eif.go <= 1'b1;
							state <= S_START;
						end else begin
							eif.cmd <= CMD_BYTE;
							eif.go <= 1'b1;
							state <= S_BYTE;
						end
					end
				end
				S_BYTE: begin
					if (eif.done) begin
						state <= S_HOLD;
						if (eif.lost) begin
							status <= ST_ARB;
							master <= 1'b0;
						end else if (addr_byte && rx_mode) begin
							status <= eif.ack ? ST_SLAR_ACK : ST_SLAR_NACK;
						end else if (addr_byte) begin
							status <= eif.ack ? ST_SLAW_ACK : ST_SLAW_NACK;
						end else begin
							status <= eif.ack ? ST_DATA_ACK : ST_DATA_NACK;
						end
					end
				end
				S_STOP: begin
					if (eif.done) begin
						master <= 1'b0;
						status <= ST_IDLE;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Events stick until a read of the event register; a new event wins
	assign evt_set = {arb_set, wr_dat && !flag, set_flag};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt <= '0;
			mask <= '0;
			irq <= 1'b0;
		end else begin
			evt <= (rd_evt ? '0 : evt) | evt_set;
			if (wr_en && wr_addr == MASK_OFF) begin
				mask <= wr_data[EVT_W-1:0];
			end
			irq <= (flag && ie) || (|(evt & mask));
		end
	end

	property p_start_code;
		@(posedge aclk) disable iff (!aresetn)
		(state == S_START && eif.done && master) |=> (status == ST_RSTART) && flag;
	endproperty
	a_start_code: assert property (p_start_code) else $error("repeated start code wrong");

	property p_addr_code;
		@(posedge aclk) disable iff (!aresetn)
		(state == S_BYTE && eif.done && !eif.lost && addr_byte && !rx_mode)
		|=> flag && (status == (eif.ack ? ST_SLAW_ACK : ST_SLAW_NACK));
	endproperty
	a_addr_code: assert property (p_addr_code) else $error("address status wrong");

	property p_data_code;
		@(posedge aclk) disable iff (!aresetn)
		(state == S_BYTE && eif.done && !eif.lost && !addr_byte)
		|=> flag && (status == ($past(eif.ack) ? ST_DATA_ACK : ST_DATA_NACK));
	endproperty
	a_data_code: assert property (p_data_code) else $error("data status wrong");

	property p_arb_code;
		@(posedge aclk) disable iff (!aresetn)
		(state == S_BYTE && eif.done && eif.lost) |=> (status == ST_ARB) && flag && !master;
	endproperty
	a_arb_code: assert property (p_arb_code) else $error("arbitration loss missed");

	property p_suspend;
		@(posedge aclk) disable iff (!aresetn)
		flag |=> !eif.go;
	endproperty
	a_suspend: assert property (p_suspend) else $error("engine started while flagged");

	property p_collision;
		@(posedge aclk) disable iff (!aresetn)
		(wr_dat && !flag) |=> wc && $stable(data_reg) ##1 evt[EVT_WC];
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged");

	property p_stop_clear;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && !wr_ctl) |=> !stop_request_bit && state == S_IDLE && status == ST_IDLE;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop bit not cleared");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		(flag && ie) [*2] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_restart;
		@(posedge aclk) disable iff (!aresetn)
		(state == S_HOLD && !flag && start_request_bit && !stop_request_bit && (status == ST_SLAW_ACK
		|| status == ST_SLAW_NACK || status == ST_DATA_ACK || status == ST_DATA_NACK))
		|=> eif.go && eif.cmd == CMD_START;
	endproperty
	a_restart: assert property (p_restart) else $error("repeated start not issued");
endmodule // twowire_master_tx_sequencer

// ---- verification/twowire_slave_model.sv ----
// Purpose: slave receiver on the open-drain two-wire bus
// Assumes: scl and sda are the resolved wired-AND line levels
// Notes: steal pulls data low after START so that the master loses arbitration
`timescale 1ns/1ps
module twowire_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic steal,
	output logic sda_low,
	output logic [7:0] last_byte,
	output logic [7:0] byte_count
);
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic ack_drv;
	logic grab;
	// Data line goes to the pull-up level whenever nothing pulls it
	assign sda_low = ack_drv | (steal & grab);
	initial begin
		bit_cnt = 4'h0;
		shift = 8'h00;
		ack_drv = 1'b0;
		grab = 1'b0;
		last_byte = 8'h00;
		byte_count = 8'h00;
	end
	// START restarts the bit framing
	always @(negedge sda) begin
		if (scl) begin
			bit_cnt = 4'h0;
			grab = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (bit_cnt < 4'h8) begin
			shift = {shift[6:0], sda};
		end
		bit_cnt = bit_cnt + 4'h1;
		if (bit_cnt == 4'h8) begin
			last_byte = shift;
		end
	end
	always @(negedge scl) begin
		if (bit_cnt == 4'h8) begin
			ack_drv = !nack;
		end else if (bit_cnt == 4'h9) begin
			ack_drv = 1'b0;
			bit_cnt = 4'h0;
			byte_count = byte_count + 8'h01;
		end
		grab = steal && (bit_cnt < 4'h8);
	end
endmodule // twowire_slave_model

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the two-wire master transmitter sequencer
// Assumes: AXI4-Lite master tasks, slave receiver model on the bus
// Notes: irq doubles as the flag watch since irq_enable stays set
`timescale 1ns/1ps
module testbench;
	import twowire_pkg::*;
	localparam logic [7:0] GO = 8'h85;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, sda_low;
	logic scl_o, sda_o;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic nack = 1'b0;
	logic steal = 1'b0;
	logic [7:0] last_byte, byte_count;
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | sda_low);
	int miscompares = 0;
	int num_checks = 0;
	always #2 aclk = ~aclk;
	twowire_master_tx_sequencer dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	twowire_slave_model slave (.scl(scl), .sda(sda), .nack(nack), .steal(steal),
		.sda_low(sda_low), .last_byte(last_byte), .byte_count(byte_count));
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bad(input string msg);
		miscompares++;
		$display("BAD at %0t: %s", $time, msg);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			bad($sformatf("%s got %h expected %h", what, got, exp));
		end
	endtask
	task automatic hang(input string what);
		bad({what, " timed out"});
		test_done();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			// Ready stays up so back-to-back calls never toggle it in one step
			if (bvalid) begin
				chk({6'h0, bresp}, {6'h0, er}, "write resp");
				return;
			end
		end
		hang("write");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk(rdata[7:0], exp, "read data");
				chk({6'h0, rresp}, {6'h0, er}, "read resp");
				return;
			end
		end
		hang("read");
	endtask
	task automatic wait_irq(input logic level, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(posedge aclk);
			if (irq === level) return;
		end
		hang("irq wait");
	endtask
	// Control write, wait for the flag, then judge the status code
	task automatic step(input logic [7:0] c, input logic [7:0] st);
		wr(CTRL_OFF, c, RESP_OKAY);
		wait_irq(1'b1, 9000);
		rd(STAT_OFF, st, RESP_OKAY);
	endtask
	task automatic send(input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
		wr(DATA_OFF, d, RESP_OKAY);
		step(c, st);
	endtask
	task automatic t_regs();
		rd(CTRL_OFF, 8'h00, RESP_OKAY);
		rd(STAT_OFF, ST_IDLE, RESP_OKAY);
		rd(DATA_OFF, DATA_RESET, RESP_OKAY);
		rd(EVT_OFF, 8'h00, RESP_OKAY);
		rd(MASK_OFF, 8'h00, RESP_OKAY);
		rd(8'h14, 8'h00, RESP_SLVERR);
		wr(8'h14, 8'h00, RESP_SLVERR);
		wr(DATA_OFF, 8'h55, RESP_OKAY);
		rd(DATA_OFF, DATA_RESET, RESP_OKAY);
		rd(CTRL_OFF, 8'h08, RESP_OKAY);
		chk({7'h0, irq}, 8'h00, "irq while masked");
		chk({6'h0, scl_o, sda_o}, 8'h00, "open-drain output levels");
		wr(MASK_OFF, 8'h02, RESP_OKAY);
		wait_irq(1'b1, 4);
		rd(EVT_OFF, 8'h02, RESP_OKAY);
		wait_irq(1'b0, 4);
		rd(EVT_OFF, 8'h00, RESP_OKAY);
		wr(MASK_OFF, 8'h00, RESP_OKAY);
		$display("test regs done");
	endtask
	task automatic t_mt();
		logic [7:0] cnt;
		step(8'hA5, ST_START);
		send(8'hA0, GO, ST_SLAW_ACK);
		chk(last_byte, 8'hA0, "address byte");
		send(8'h3C, GO, ST_DATA_ACK);
		chk(last_byte, 8'h3C, "data byte");
		nack <= 1'b1;
		send(8'h81, GO, ST_DATA_NACK);
		nack <= 1'b0;
		cnt = byte_count;
		idle(2000);
		chk(byte_count, cnt, "bus quiet while flag set");
		chk({7'h0, irq}, 8'h01, "irq holds");
		wr(CTRL_OFF, 8'h95, RESP_OKAY);
		idle(1500);
		chk({6'h0, scl, sda}, 8'h03, "bus free after stop");
		rd(CTRL_OFF, 8'h05, RESP_OKAY);
		$display("test transmit done");
	endtask
	// After a START only an address may follow, so each run sends one before STOP
	task automatic t_rs();
		step(8'hA5, ST_START);
		nack <= 1'b1;
		send(8'hA0, GO, ST_SLAW_NACK);
		step(8'hA5, ST_RSTART);
		send(8'hA1, GO, ST_SLAR_NACK);
		nack <= 1'b0;
		step(8'hA5, ST_RSTART);
		send(8'hB0, GO, ST_SLAW_ACK);
		chk(last_byte, 8'hB0, "new address");
		step(8'hB5, ST_START);
		rd(CTRL_OFF, 8'hA5, RESP_OKAY);
		send(8'hA0, GO, ST_SLAW_ACK);
		wr(CTRL_OFF, 8'h95, RESP_OKAY);
		idle(1500);
		$display("test repeated start done");
	endtask
	task automatic t_arb();
		steal <= 1'b1;
		step(8'hA5, ST_START);
		send(8'hA0, GO, ST_ARB);
		wr(CTRL_OFF, GO, RESP_OKAY);
		idle(20);
		rd(STAT_OFF, ST_IDLE, RESP_OKAY);
		chk({6'h0, scl_oe, sda_oe}, 8'h00, "bus released");
		steal <= 1'b0;
		idle(1500);
		steal <= 1'b1;
		step(8'hA5, ST_START);
		send(8'hA0, GO, ST_ARB);
		wr(CTRL_OFF, 8'hA5, RESP_OKAY);
		idle(2000);
		chk({7'h0, irq}, 8'h00, "no start on busy bus");
		steal <= 1'b0;
		wait_irq(1'b1, 9000);
		rd(STAT_OFF, ST_START, RESP_OKAY);
		send(8'hA0, GO, ST_SLAW_ACK);
		wr(CTRL_OFF, 8'h95, RESP_OKAY);
		idle(1500);
		$display("test arbitration done");
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_mt();
		t_rs();
		t_arb();
		test_done();
	end
endmodule // testbench
